//--- verilog/fcs_pkg.sv
// Purpose: constants for the flash configuration status register bank
// Assumes: opcodes arrive already decoded from the serial command stream
// Notes: register 3 and 4 values are volatile copies held in flip-flops
package fcs_pkg;
  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  localparam logic [7:0] OP_WRSR3 = 8'h11;
  localparam logic [7:0] OP_WRSR4 = 8'h71;
  localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;
  localparam logic [7:0] OP_BLOCK_UNLOCK = 8'h39;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_DEEPEST = 8'h79;
  localparam logic [7:0] OP_WAKE = 8'hAB;
  // ****************************************
  // register 3 layout
  // ****************************************
  localparam int PIN_ROLE_BIT = 7;
  localparam int STRENGTH_HI = 6;
  localparam int STRENGTH_LO = 5;
  localparam int SCHEME_BIT = 2;
  localparam logic [7:0] CFG3_RESET = 8'h20;
  localparam logic [7:0] CFG3_WMASK = 8'hE4;
  // ****************************************
  // register 4 layout
  // ****************************************
  localparam int DEPTH_BIT = 7;
  localparam logic [7:0] CFG4_RESET = 8'h00;
  localparam logic [7:0] CFG4_WMASK = 8'h80;
  // ****************************************
  // block locks, reserved strength and sleep states
  // ****************************************
  localparam int NUM_BLOCKS = 32;
  localparam int BLOCK_W = 5;
  localparam logic [1:0] STRENGTH_RESERVED = 2'h0;
  typedef enum logic [1:0] {
    SLP_AWAKE = 2'b00,
    SLP_LIGHT = 2'b01,
    SLP_DEEPEST = 2'b10
  } fcs_sleep_t;
endpackage : fcs_pkg

//--- verilog/fcs_lock_cell.sv
// Purpose: one per-block lock bit
// Assumes: lock and unlock never pulse together
// Notes: any reset forces the bit to locked
`timescale 1ns/1ps
module fcs_lock_cell (
  // clock and resets
  input wire logic clock,
  input wire logic rstn,
  input wire logic syncReset,
  // updates
  input wire logic lockSet,
  input wire logic lockClear,
  // state
  output logic locked
);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      locked <= 1'b1;
    end else if (syncReset || lockSet) begin
      locked <= 1'b1;
    end else if (lockClear) begin
      locked <= 1'b0;
    end
  end
endmodule : fcs_lock_cell

//--- verilog/fcs_config_regs.sv
// Purpose: pin role, drive strength, protection scheme and sleep depth config
// Assumes: cmdValid is a one-cycle pulse per completed command from the decoder
// Notes: writes need the write latch and no status protection
`timescale 1ns/1ps
module fcs_config_regs (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // decoded commands
  input wire logic cmdValid,
  input wire logic [7:0] cmdOpcode,
  input wire logic [7:0] cmdData,
  input wire logic [4:0] cmdBlock,
  // write permission and related state
  input wire logic writeLatch,
  input wire logic statusProtected,
  input wire logic quadEnable,
  input wire logic softReset,
  input wire logic chipSelectN,
  // multi-purpose pin, asynchronous
  input wire logic mpPinN,
  // protection query
  input wire logic [4:0] queryBlock,
  // outputs
  output logic [7:0] cfg3Value,
  output logic [7:0] cfg4Value,
  output logic holdActive,
  output logic pinResetActive,
  output logic [1:0] outputStrength,
  output logic rangeProtectMode,
  output logic queryLocked,
  output logic [1:0] sleepState,
  output logic pageBufferValid
);
  // ****************************************
  // pin synchroniser
  // ****************************************
  logic pinS1_r;
  logic pinS2_r;
  logic pinS3_r;
  logic pinLevel_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pinS1_r <= 1'b1;
      pinS2_r <= 1'b1;
      pinS3_r <= 1'b1;
      pinLevel_r <= 1'b1;
    end else begin
      pinS1_r <= mpPinN;
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
      if (pinS2_r == pinS3_r) begin
        pinLevel_r <= pinS3_r;
      end
    end
  end

  // ****************************************
  // command qualification
  // ****************************************
  fcs_pkg::fcs_sleep_t sleep_r;
  fcs_pkg::fcs_sleep_t sleep_nxt;
  logic [7:0] cfg3_r;
  logic [7:0] cfg4_r;
  logic awake;
  logic statusWrite;
  logic pinResetNow;
  assign awake = (sleep_r == fcs_pkg::SLP_AWAKE);
  assign statusWrite = cmdValid && awake && writeLatch && !statusProtected;
  // pin role applies only with quad off
  assign pinResetNow = cfg3_r[fcs_pkg::PIN_ROLE_BIT] && !quadEnable && !pinLevel_r;

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg3_r <= fcs_pkg::CFG3_RESET;
    end else if (statusWrite && cmdOpcode == fcs_pkg::OP_WRSR3) begin
      // pin role written at bit 7
      cfg3_r <= cmdData & fcs_pkg::CFG3_WMASK;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg4_r <= fcs_pkg::CFG4_RESET;
    end else if (statusWrite && cmdOpcode == fcs_pkg::OP_WRSR4) begin
      cfg4_r <= cmdData & fcs_pkg::CFG4_WMASK;
    end
  end

  // ****************************************
  // block locks
  // ****************************************
  logic [fcs_pkg::NUM_BLOCKS-1:0] locks;
  logic lockCmd;
  logic unlockCmd;
  logic anyReset;
  // lock commands only in block mode
  assign lockCmd = cmdValid && awake && cfg3_r[fcs_pkg::SCHEME_BIT] &&
                   cmdOpcode == fcs_pkg::OP_BLOCK_LOCK;
  assign unlockCmd = cmdValid && awake && cfg3_r[fcs_pkg::SCHEME_BIT] &&
                     cmdOpcode == fcs_pkg::OP_BLOCK_UNLOCK;
  // soft and pin resets relock all
  assign anyReset = softReset || pinResetNow;

  genvar gi;
  generate
    for (gi = 0; gi < fcs_pkg::NUM_BLOCKS; gi = gi + 1) begin : g_lock
      fcs_lock_cell u_cell (
        .clock(clock),
        .rstn(rstn),
        .syncReset(anyReset),
        .lockSet(lockCmd && cmdBlock == 5'(gi)),
        .lockClear(unlockCmd && cmdBlock == 5'(gi)),
        .locked(locks[gi])
      );
    end
  endgenerate

  // ****************************************
  // sleep state machine
  // ****************************************
  always_comb begin
    sleep_nxt = sleep_r;
    case (sleep_r)
      fcs_pkg::SLP_AWAKE: begin
        if (cmdValid && cmdOpcode == fcs_pkg::OP_SLEEP) begin
          sleep_nxt = cfg4_r[fcs_pkg::DEPTH_BIT] ? fcs_pkg::SLP_LIGHT : fcs_pkg::SLP_DEEPEST;
        end else if (cmdValid && cmdOpcode == fcs_pkg::OP_DEEPEST) begin
          sleep_nxt = fcs_pkg::SLP_DEEPEST;
        end
      end
      fcs_pkg::SLP_LIGHT, fcs_pkg::SLP_DEEPEST: begin
        if (cmdValid && cmdOpcode == fcs_pkg::OP_WAKE) begin
          sleep_nxt = fcs_pkg::SLP_AWAKE;
        end
      end
      default: begin
        sleep_nxt = fcs_pkg::SLP_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sleep_r <= fcs_pkg::SLP_AWAKE;
    end else begin
      sleep_r <= sleep_nxt;
    end
  end

  // page buffer contents survive light sleep only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pageBufferValid <= 1'b0;
    end else if (sleep_nxt == fcs_pkg::SLP_DEEPEST && awake) begin
      pageBufferValid <= 1'b0;
    end else if (awake && cmdValid) begin
      pageBufferValid <= 1'b1;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg3Value <= fcs_pkg::CFG3_RESET;
      cfg4Value <= fcs_pkg::CFG4_RESET;
      holdActive <= 1'b0;
      pinResetActive <= 1'b0;
      outputStrength <= fcs_pkg::CFG3_RESET[fcs_pkg::STRENGTH_HI:fcs_pkg::STRENGTH_LO];
      rangeProtectMode <= 1'b1;
      queryLocked <= 1'b0;
      sleepState <= fcs_pkg::SLP_AWAKE;
    end else begin
      cfg3Value <= cfg3_r;
      cfg4Value <= cfg4_r;
      // hold applies only with quad off
      holdActive <= !cfg3_r[fcs_pkg::PIN_ROLE_BIT] && !quadEnable && !pinLevel_r;
      pinResetActive <= pinResetNow;
      outputStrength <= cfg3_r[fcs_pkg::STRENGTH_HI:fcs_pkg::STRENGTH_LO];
      rangeProtectMode <= !cfg3_r[fcs_pkg::SCHEME_BIT];
      queryLocked <= cfg3_r[fcs_pkg::SCHEME_BIT] && locks[queryBlock];
      sleepState <= sleep_r;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_reserved_zero: assert property (
    @(posedge clock) disable iff (!rstn) (cfg3Value & ~fcs_pkg::CFG3_WMASK) == 8'h00)
    else $error("reserved config bits not zero");
  a_quad_no_hold: assert property (
    @(posedge clock) disable iff (!rstn) quadEnable |=> !holdActive && !pinResetActive)
    else $error("pin function active with quad on");
  a_role_reset: assert property (
    @(posedge clock) disable iff (!rstn)
    cfg3_r[fcs_pkg::PIN_ROLE_BIT] && !quadEnable && !pinLevel_r |=> pinResetActive && !holdActive)
    else $error("reset role not honoured");
  a_write_gate: assert property (
    @(posedge clock) disable iff (!rstn)
    cmdValid && cmdOpcode == fcs_pkg::OP_WRSR3 && !writeLatch |=> $stable(cfg3_r))
    else $error("status written without latch");
  a_lock_cmd: assert property (
    @(posedge clock) disable iff (!rstn) unlockCmd && !anyReset |=> !locks[$past(cmdBlock)])
    else $error("unlock did not clear lock bit");
  a_relock_all: assert property (
    @(posedge clock) disable iff (!rstn) softReset |=> &locks)
    else $error("locks not set after reset");
  a_depth_deep: assert property (
    @(posedge clock) disable iff (!rstn)
    awake && cmdValid && cmdOpcode == fcs_pkg::OP_SLEEP && !cfg4_r[fcs_pkg::DEPTH_BIT]
    |=> sleep_r == fcs_pkg::SLP_DEEPEST ##1 !pageBufferValid)
    else $error("deepest sleep not entered");
  a_depth_light: assert property (
    @(posedge clock) disable iff (!rstn)
    awake && cmdValid && cmdOpcode == fcs_pkg::OP_SLEEP &&
    cfg4_r[fcs_pkg::DEPTH_BIT] && pageBufferValid
    |=> sleep_r == fcs_pkg::SLP_LIGHT ##1 pageBufferValid)
    else $error("light sleep wrong");
  a_wake_only: assert property (
    @(posedge clock) disable iff (!rstn)
    !awake && !(cmdValid && cmdOpcode == fcs_pkg::OP_WAKE) |=> !awake)
    else $error("woke without wake opcode");
  a_scheme_out: assert property (
    @(posedge clock) disable iff (!rstn) cfg3_r[fcs_pkg::SCHEME_BIT] |=> !rangeProtectMode)
    else $error("protection scheme output wrong");
  c_deep_wake: cover property (@(posedge clock) disable iff (!rstn)
    sleep_r == fcs_pkg::SLP_DEEPEST ##[1:20] awake);
  c_light: cover property (@(posedge clock) disable iff (!rstn)
    sleep_r == fcs_pkg::SLP_LIGHT);
  c_unlock: cover property (@(posedge clock) disable iff (!rstn) unlockCmd);
  c_cs_asleep: cover property (@(posedge clock) disable iff (!rstn) !awake && !chipSelectN);
endmodule : fcs_config_regs

//--- verif/fcs_host_model.sv
// Purpose: host side that issues decoded flash commands to the config bank
// Assumes: one command per call, taken on the edge after it is driven
// Notes: released command lines show the inverse of the last byte
`timescale 1ns/1ps
module fcs_host_model (
  // clock
  input wire logic clock,
  // command lines
  output logic cmdValid,
  output logic [7:0] cmdOpcode,
  output logic [7:0] cmdData,
  output logic [4:0] cmdBlock
);
  initial begin
    cmdValid = 1'b0;
    cmdOpcode = 8'h00;
    cmdData = 8'h00;
    cmdBlock = 5'h00;
  end
  // ****************************************
  // command issue
  // ****************************************
  // host opcodes
  task automatic send(input logic [7:0] op, input logic [7:0] d, input logic [4:0] b);
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdOpcode <= op;
    cmdData <= d;
    cmdBlock <= b;
    @(posedge clock);
    // stale bytes would hide a late sample, so invert them
    cmdValid <= 1'b0;
    cmdOpcode <= ~op;
    cmdData <= ~d;
    cmdBlock <= ~b;
  endtask : send
endmodule : fcs_host_model

//--- verif/tb.sv
// Purpose: self-checking bench for the config status bank
// Assumes: outputs settle one edge after the taking edge
// Notes: expectations queue up, a monitor compares them at the falling edge
`timescale 1ns/1ps
module tb;
  logic clock, rstn, writeLatch, statusProtected, quadEnable, softReset;
  logic chipSelectN, mpPinN, cmdValid;
  logic [4:0] queryBlock, cmdBlock;
  logic [7:0] cmdOpcode, cmdData, cfg3Value, cfg4Value;
  logic [1:0] outputStrength, sleepState;
  logic holdActive, pinResetActive, rangeProtectMode, queryLocked, pageBufferValid;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [31:0] rngState = 32'h48;
  typedef struct {int sel; logic [7:0] exp;} fcs_note_t;
  fcs_note_t noteQ[$];
  string names[9] = '{"cfg3Value", "cfg4Value", "outputStrength", "rangeProtectMode",
    "queryLocked", "sleepState", "pageBufferValid", "holdActive", "pinResetActive"};

  fcs_config_regs u_dut (.clock, .rstn, .cmdValid, .cmdOpcode, .cmdData, .cmdBlock,
    .writeLatch, .statusProtected, .quadEnable, .softReset, .chipSelectN, .mpPinN,
    .queryBlock, .cfg3Value, .cfg4Value, .holdActive, .pinResetActive, .outputStrength,
    .rangeProtectMode, .queryLocked, .sleepState, .pageBufferValid);
  fcs_host_model u_host (.clock, .cmdValid, .cmdOpcode, .cmdData, .cmdBlock);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] rnd();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState[7:0];
  endfunction : rnd
  function automatic logic [7:0] pick(input int sel);
    case (sel)
      0: return cfg3Value;
      1: return cfg4Value;
      2: return {6'h00, outputStrength};
      3: return {7'h00, rangeProtectMode};
      4: return {7'h00, queryLocked};
      5: return {6'h00, sleepState};
      6: return {7'h00, pageBufferValid};
      7: return {7'h00, holdActive};
      default: return {7'h00, pinResetActive};
    endcase
  endfunction : pick
  task automatic note(input int sel, input logic [7:0] exp);
    noteQ.push_back('{sel, exp});
  endtask : note
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
  endtask : settle
  task automatic cmd(input logic [7:0] op, input logic [7:0] d, input logic [4:0] b);
    u_host.send(op, d, b);
    settle(2);
  endtask : cmd
  task automatic blk(input logic [7:0] op, input logic [4:0] b, input logic [7:0] e);
    queryBlock <= b;
    cmd(op, 8'h00, b);
    note(4, e);
  endtask : blk
  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  // ****************************************
  // monitor
  // ****************************************
  initial begin
    fcs_note_t n;
    forever begin
      wait (noteQ.size() > 0);
      @(negedge clock);
      while (noteQ.size() > 0) begin
        n = noteQ.pop_front();
        cmp_count++;
        if (pick(n.sel) !== n.exp) begin
          n_mismatch++;
          $display("ERROR %s expected %0h seen %0h", names[n.sel], n.exp, pick(n.sel));
        end
      end
    end
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    n_mismatch++;
    give_verdict();
  end
  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    logic [7:0] d;
    rstn = 1'b0;
    writeLatch = 1'b1;
    statusProtected = 1'b0;
    quadEnable = 1'b0;
    softReset = 1'b0;
    chipSelectN = 1'b1;
    mpPinN = 1'b1;
    queryBlock = 5'h00;
    settle(3);
    rstn <= 1'b1;
    settle(1);
    note(0, 8'h20);
    note(1, 8'h00);
    note(2, 8'h01);
    note(3, 8'h01);
    note(5, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      d[6:5] = i[1:0];
      d[2] = i[0];
      cmd(fcs_pkg::OP_WRSR3, d, 5'h00);
      note(0, d & fcs_pkg::CFG3_WMASK);
      note(2, {6'h00, d[6:5]});
      note(3, {7'h00, ~d[2]});
    end
    writeLatch <= 1'b0;
    cmd(fcs_pkg::OP_WRSR3, 8'h04, 5'h00);
    writeLatch <= 1'b1;
    statusProtected <= 1'b1;
    cmd(fcs_pkg::OP_WRSR3, 8'h04, 5'h00);
    note(0, d & fcs_pkg::CFG3_WMASK);
    statusProtected <= 1'b0;
    blk(fcs_pkg::OP_BLOCK_UNLOCK, 5'h05, 8'h00);
    blk(fcs_pkg::OP_BLOCK_LOCK, 5'h05, 8'h01);
    blk(fcs_pkg::OP_BLOCK_UNLOCK, 5'h09, 8'h00);
    softReset <= 1'b1;
    settle(1);
    softReset <= 1'b0;
    settle(2);
    note(4, 8'h01);
    cmd(fcs_pkg::OP_WRSR3, 8'h20, 5'h00);
    blk(fcs_pkg::OP_BLOCK_UNLOCK, 5'h09, 8'h00);
    cmd(fcs_pkg::OP_WRSR3, 8'h24, 5'h00);
    note(4, 8'h01);
    mpPinN <= 1'b0;
    settle(8);
    note(7, 8'h01);
    note(8, 8'h00);
    cmd(fcs_pkg::OP_WRSR3, 8'hA4, 5'h00);
    settle(2);
    note(7, 8'h00);
    note(8, 8'h01);
    quadEnable <= 1'b1;
    settle(8);
    note(7, 8'h00);
    note(8, 8'h00);
    quadEnable <= 1'b0;
    mpPinN <= 1'b1;
    settle(8);
    cmd(fcs_pkg::OP_SLEEP, 8'h00, 5'h00);
    note(5, 8'h02);
    note(6, 8'h00);
    chipSelectN <= 1'b0;
    settle(1);
    chipSelectN <= 1'b1;
    cmd(fcs_pkg::OP_WRSR3, 8'h00, 5'h00);
    note(5, 8'h02);
    note(0, 8'hA4);
    cmd(fcs_pkg::OP_WAKE, 8'h00, 5'h00);
    note(5, 8'h00);
    cmd(fcs_pkg::OP_WRSR4, 8'hFF, 5'h00);
    note(1, 8'h80);
    note(6, 8'h01);
    cmd(fcs_pkg::OP_SLEEP, 8'h00, 5'h00);
    note(5, 8'h01);
    note(6, 8'h01);
    cmd(fcs_pkg::OP_WAKE, 8'h00, 5'h00);
    cmd(fcs_pkg::OP_DEEPEST, 8'h00, 5'h00);
    note(5, 8'h02);
    note(6, 8'h00);
    cmd(fcs_pkg::OP_WAKE, 8'h00, 5'h00);
    note(5, 8'h00);
    settle(2);
    give_verdict();
  end
endmodule : tb
